// >>> sbd_adder.v
`timescale 1ns/1ps
`include "sbd_consts.vh"
// eight-bit adder with carry, half carry and signed overflow outputs
module sbd_adder (
    input  wire [`SBD_DW-1:0] opA,
    input  wire [`SBD_DW-1:0] opB,
    input  wire               carryIn,
    output wire [`SBD_DW-1:0] sum,
    output wire               carryOut,
    output wire               halfCarry,
    output wire               overflow
);
    wire [`SBD_NIB:0] lowSum;
    wire [`SBD_DW:0]  fullSum;

    // low nibble gives half carry, full width gives carry
    assign lowSum    = {1'b0, opA[`SBD_NIB-1:0]} + {1'b0, opB[`SBD_NIB-1:0]} + {4'h0, carryIn};
    assign fullSum   = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
    assign sum       = fullSum[`SBD_DW-1:0];
    assign carryOut  = fullSum[`SBD_DW];
    assign halfCarry = lowSum[`SBD_NIB];
    // signed overflow: like signs in, different sign out
    assign overflow  = (opA[`SBD_MSB] == opB[`SBD_MSB]) && (sum[`SBD_MSB] != opA[`SBD_MSB]);
endmodule // sbd_adder

// >>> sbd_consts.vh
`ifndef SBD_CONSTS_VH
`define SBD_CONSTS_VH
// operation select codes on opSel
`define SBD_OP_W          2
`define SBD_OP_SUB_WORK   2'h0
`define SBD_OP_SUB_MEM    2'h1
`define SBD_OP_DEC_MEM    2'h2
`define SBD_OP_DEC_WORK   2'h3
// data width and constants
`define SBD_DW            8
`define SBD_ZERO          8'h00
`define SBD_ONE           8'h01
`define SBD_MSB           7
`define SBD_NIB           4
// flag register layout
`define SBD_FLAGS_W       4
`define SBD_FLAG_C        0
`define SBD_FLAG_AC       1
`define SBD_FLAG_Z        2
`define SBD_FLAG_OV       3
`define SBD_FLAGS_RST     4'h0
`define SBD_WORK_RST      8'h00
`endif

// >>> sbd_exec_unit.v
// Function
// - subtract-borrow result goes to work register
// - subtract-borrow-to-memory result written to memory
// - decrement memory, write back, skip if zero
// - skip discards fetched instruction, one dummy cycle
// - nonzero decrement continues, single cycle
// - decrement-to-work loads work, skips if zero
// - decrement-to-work leaves memory unchanged
`timescale 1ns/1ps
`include "sbd_consts.vh"
module sbd_exec_unit (
    input  wire                   core_clk,
    input  wire                   sys_rst,
    input  wire                   execValid,
    input  wire [`SBD_OP_W-1:0]   opSel,
    input  wire [`SBD_DW-1:0]     memRdData,
    input  wire [`SBD_FLAGS_W-1:0] flagsIn,
    output reg  [`SBD_DW-1:0]     workReg_r,
    output reg  [`SBD_FLAGS_W-1:0] flags_r,
    output reg                    memWrEn_r,
    output reg  [`SBD_DW-1:0]     memWrData_r,
    output reg                    discardFetch_r,
    output reg                    busy_r
);
    // execution states, one-hot
    localparam [1:0] ST_RUN   = 2'b01;
    localparam [1:0] ST_DUMMY = 2'b10;

    reg  [1:0]               state_r;
    reg  [1:0]               state_nxt;
    wire [`SBD_DW-1:0]       addSum;
    wire                     addCarry;
    wire                     addHalf;
    wire                     addOver;
    wire [`SBD_DW-1:0]       decVal;
    wire                     decZero;
    wire                     isSub;
    wire                     isDec;
    wire                     take;
    wire                     skipNow;

    // decode of the operation class, used in several places
    function isSubOp;
        input [`SBD_OP_W-1:0] op;
        begin
            isSubOp = (op == `SBD_OP_SUB_WORK) || (op == `SBD_OP_SUB_MEM);
        end
    endfunction

    // work plus inverted memory byte plus carry
    sbd_adder uAdder (
        .opA       (workReg_r),
        .opB       (~memRdData),
        .carryIn   (flagsIn[`SBD_FLAG_C]),
        .sum       (addSum),
        .carryOut  (addCarry),
        .halfCarry (addHalf),
        .overflow  (addOver)
    );

    // decrement path and zero test
    assign decVal  = memRdData - `SBD_ONE;
    assign decZero = (decVal == `SBD_ZERO);
    assign isSub   = isSubOp(opSel);
    assign isDec   = !isSubOp(opSel);
    // instructions are accepted only in the run state
    assign take    = execValid && state_r[0];
    assign skipNow = take && isDec && decZero;

    // next state: a taken skip spends one dummy cycle
    always @* begin
        case (state_r)
            ST_RUN: begin
                if (skipNow) begin
                    state_nxt = ST_DUMMY;
                end else begin
                    state_nxt = ST_RUN;
                end
            end
            ST_DUMMY: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // state, discard and busy registers
    always @(posedge core_clk) begin
        if (sys_rst) begin
            state_r        <= ST_RUN;
            discardFetch_r <= 1'b0;
            busy_r         <= 1'b0;
        end else begin
            state_r        <= state_nxt;
            discardFetch_r <= skipNow;
            busy_r         <= skipNow;
        end
    end

    // work register updates
    always @(posedge core_clk) begin
        if (sys_rst) begin
            workReg_r <= `SBD_WORK_RST;
        end else if (take && opSel == `SBD_OP_SUB_WORK) begin
            workReg_r <= addSum;
        end else if (take && opSel == `SBD_OP_DEC_WORK) begin
            workReg_r <= decVal;
        end
    end

    // memory write-back: only the to-memory forms write
    always @(posedge core_clk) begin
        if (sys_rst) begin
            memWrEn_r   <= 1'b0;
            memWrData_r <= `SBD_ZERO;
        end else begin
            memWrEn_r <= take && (opSel == `SBD_OP_SUB_MEM || opSel == `SBD_OP_DEC_MEM);
            if (take && opSel == `SBD_OP_SUB_MEM) begin
                memWrData_r <= addSum;
            end else if (take && opSel == `SBD_OP_DEC_MEM) begin
                memWrData_r <= decVal;
            end
        end
    end

    // flags: subtracts load all four, otherwise follow flagsIn
    always @(posedge core_clk) begin
        if (sys_rst) begin
            flags_r <= `SBD_FLAGS_RST;
        end else if (take && isSub) begin
            flags_r[`SBD_FLAG_C]  <= addCarry;
            flags_r[`SBD_FLAG_AC] <= addHalf;
            flags_r[`SBD_FLAG_Z]  <= (addSum == `SBD_ZERO);
            flags_r[`SBD_FLAG_OV] <= addOver;
        end else begin
            flags_r <= flagsIn;
        end
    end
endmodule // sbd_exec_unit

// >>> sbd_exec_unit_assertions.sv
`timescale 1ns/1ps
module sbd_exec_unit_assertions (
    input       core_clk,
    input       sys_rst,
    input       execValid,
    input [1:0] opSel,
    input [7:0] memRdData,
    input [3:0] flagsIn,
    input [7:0] workReg_r,
    input [3:0] flags_r,
    input       memWrEn_r,
    input [7:0] memWrData_r,
    input       discardFetch_r,
    input       busy_r
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // taken request, sum and decrement
    wire       tk = execValid && !busy_r;
    wire [8:0] s = workReg_r + {1'b0, ~memRdData} + flagsIn[0];
    wire [7:0] sr = s[7:0];
    wire       cy = s[8];
    wire [7:0] dm = memRdData - 8'h01;
    chk_sub_work: assert property (tk && opSel == 2'h0 |=> workReg_r == $past(sr)) else $error("sub work");
    chk_sub_mem: assert property (tk && opSel == 2'h1 |=> memWrEn_r && memWrData_r == $past(sr)) else $error("sub mem");
    chk_dec_mem: assert property (tk && opSel == 2'h2 |=> memWrEn_r && memWrData_r == $past(dm)) else $error("dec mem");
    chk_skip_len: assert property (tk && opSel[1] && dm == 8'h00 |=> discardFetch_r && busy_r ##1 !busy_r) else $error("skip");
    chk_no_skip: assert property (tk && opSel[1] && dm != 8'h00 |=> !discardFetch_r && !busy_r) else $error("no skip");
    chk_dec_work: assert property (tk && opSel == 2'h3 |=> workReg_r == $past(dm) && !memWrEn_r) else $error("dec work");
    chk_flag_keep: assert property (tk && opSel[1] |=> flags_r == $past(flagsIn)) else $error("flags kept");
    chk_sub_flags: assert property (tk && !opSel[1] |=> flags_r[0] == $past(cy) && flags_r[2] == ($past(sr) == 8'h00))
        else $error("sub flags");
    cover property (tk && opSel == 2'h1);
    cover property (discardFetch_r);
    cover property (tk && opSel == 2'h3 && dm == 8'h00);
endmodule // sbd_exec_unit_assertions
bind sbd_exec_unit sbd_exec_unit_assertions sbd_exec_unit_assertions_inst (.*);

// >>> sbd_mem_model.sv
`timescale 1ns/1ps
// one memory byte: bench preload, unit write-back
module sbd_mem_model (
    input            core_clk,
    input            loadEn,
    input      [7:0] loadData,
    input            wrEn,
    input      [7:0] wrData,
    output reg [7:0] rdData
);
    // preload wins over write-back
    always @(posedge core_clk) begin
        if (loadEn) rdData <= loadData;
        else if (wrEn) rdData <= wrData;
    end
endmodule // sbd_mem_model

// >>> test_subtract_borrow_decrement_skip.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_subtract_borrow_decrement_skip;
    reg        core_clk = 0, sys_rst = 1, execValid = 0, loadEn = 0, tkd = 0;
    reg  [1:0] opSel = 2'h0;
    reg  [7:0] loadData = 8'h00, wk = 8'h00;
    reg  [3:0] flagsIn = 4'h0;
    wire [7:0] memRdData, workReg_r, memWrData_r;
    wire [3:0] flags_r;
    wire       memWrEn_r, discardFetch_r, busy_r;
    int        fail_count = 0, cmp_count = 0;
    reg [21:0] q[$];
    sbd_exec_unit sbd_exec_unit_inst (.*);
    sbd_mem_model sbd_mem_model_inst (.core_clk(core_clk), .loadEn(loadEn), .loadData(loadData),
        .wrEn(memWrEn_r), .wrData(memWrData_r), .rdData(memRdData));
    always #5 core_clk = ~core_clk;
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // preload memory, issue one instruction, note expected result
    task run(input [1:0] o, input [7:0] m);
        reg [8:0] s;
        reg [7:0] dm;
        reg       dsc;
        reg [4:0] h;
        reg       ac;
        reg       ov;
        begin
            @(posedge core_clk);
            loadEn <= 1'b1;
            loadData <= m;
            flagsIn <= $urandom;
            @(posedge core_clk);
            loadEn <= 1'b0;
            execValid <= 1'b1;
            opSel <= o;
            s = wk + {1'b0, ~m} + flagsIn[0];
            dm = m - 8'h01;
            h = {1'b0, wk[3:0]} + {1'b0, ~m[3:0]} + {4'h0, flagsIn[0]};
            ac = h[4];
            ov = (wk[7] == ~m[7]) && (s[7] != wk[7]);
            dsc = o[1] && dm == 8'h00;
            wk = (o == 2'h0) ? s[7:0] : (o == 2'h3) ? dm : wk;
            q.push_back({wk, o == 2'h1 || o == 2'h2, o == 2'h1 ? s[7:0] : o == 2'h2 ? dm : 8'h00, dsc,
                o[1] ? flagsIn[0] : s[8], o[1] ? flagsIn[2] : s[7:0] == 8'h00,
                o[1] ? flagsIn[1] : ac, o[1] ? flagsIn[3] : ov});
            @(posedge core_clk);
            execValid <= dsc; // offered in the dummy cycle, must be ignored
            @(posedge core_clk);
            execValid <= 1'b0;
        end
    endtask
    // result shows one cycle after a taken request
    always @(posedge core_clk) tkd <= execValid && !busy_r && !sys_rst;
    always @(negedge core_clk) if (tkd) begin
        if (q.size() == 0) begin fail_count++; $display("[ERR] %0t no note", $time); end
        else `CHK({workReg_r, memWrEn_r, memWrEn_r ? memWrData_r : 8'h00, discardFetch_r, flags_r[0], flags_r[2], flags_r[1], flags_r[3]}, q.pop_front())
    end
    // every op with skip, no-skip and random bytes
    initial begin
        void'($urandom(42));
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            run(i[1:0], 8'h01);
            run(i[1:0], 8'h02);
            run(i[1:0], $urandom);
            $display("op %0d done", i);
        end
        repeat (4) @(posedge core_clk);
        finish_test;
    end
endmodule // test_subtract_borrow_decrement_skip
